// ---- bench/smpt_mem_model.sv ----
// asynchronous memory at the pins: read data is a function of address
// assumes: driven by the core select, read strobe and address pins
`timescale 1ns/10ps
module smpt_mem_model (
  input  wire logic [3:0]  chip_select_n_i,
  input  wire logic        read_strobe_n_i,
  input  wire logic [23:0] addr_i,
  output logic      [15:0] data_o
);
  // no wait line at all, so wait handling never meets page mode
  // released bus shows the inverse so a stale capture cannot match
  always @* begin
    if (!(&chip_select_n_i) && !read_strobe_n_i) begin
      data_o = addr_i[15:0] ^ 16'hC3A5;
    end else begin
      data_o = ~(addr_i[15:0] ^ 16'hC3A5);
    end
  end
endmodule // smpt_mem_model

// ---- bench/smpt_page_ctrl_properties.sv ----
// checker on the core ports: bus handshakes, access pulses, pins
// assumes: bound to smpt_page_ctrl from the bench top file
`timescale 1ns/10ps
module smpt_chk (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        req_valid_i,
  input wire logic        req_ready_o,
  input wire logic        resp_valid_o,
  input wire logic [3:0]  chip_select_n_o,
  input wire logic        read_strobe_n_o,
  input wire logic        mem_data_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // accepted access request
  wire acc = req_valid_i && req_ready_o;
  wr_hold_a: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
    && $stable(s_axi_bresp_o)) else $error("write answer dropped");
  wr_refuse_a: assert property (
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answer pending");
  rd_hold_a: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
    && $stable(s_axi_rdata_o)) else $error("read answer dropped");
  rd_once_a: assert property (
    s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read answer repeated");
  busy_block_a: assert property (acc |=> !req_ready_o)
    else $error("request taken while busy");
  resp_pulse_a: assert property (
    resp_valid_o |=> !resp_valid_o) else $error("response too long");
  resp_bound_a: assert property (
    acc |-> ##[2:1000] resp_valid_o) else $error("access never ended");
  one_select_a: assert property (
    $onehot0(~chip_select_n_o)) else $error("two selects active");
  read_dir_a: assert property (
    !read_strobe_n_o |-> !mem_data_oe_o) else $error("bus driven in read");
endmodule // smpt_chk

// ---- bench/tb_top.sv ----
// bench top: register bus, access timing and page-mode data checks
// assumes: core, memory model and checker compiled before this file
`timescale 1ns/10ps
module tb_top;
  logic        clk_i = 0, rstn_i = 0, awvalid = 0, wvalid = 0;
  logic        bready = 0, arvalid = 0, rready = 0, rq = 0, wr = 0;
  logic        other = 0, slow = 0, awready, wready, bvalid, arready;
  logic        rvalid, rdy, rsp, rd_n, wr_n;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0]  bresp, rresp, lr, bsn, cs = 0;
  logic [23:0] addr = 0, maddr;
  logic [15:0] rdat, mdi, mdo;
  logic [3:0]  csn;
  logic [31:0] rv [4] = '{32'h01010101, 32'h01010101, 32'h00030003,
                         32'h10002103};
  int          n_mismatch = 0, tests_run = 0, cyc = 0;

  always #2 clk_i = ~clk_i;

  smpt_page_ctrl dut (.clk_i(clk_i), .rstn_i(rstn_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .req_valid_i(rq), .req_ready_o(rdy),
    .req_write_i(wr), .req_cs_i(cs), .req_addr_i(addr),
    .req_be_i(2'h3), .req_wdata_i(16'h1234), .resp_valid_o(rsp),
    .resp_rdata_o(rdat), .other_access_i(other),
    .slow_clk_req_i(slow), .chip_select_n_o(csn),
    .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .byte_sel_n_o(bsn),
    .mem_addr_o(maddr), .mem_data_o(mdo), .mem_data_oe_o(),
    .mem_data_i(mdi));
  smpt_mem_model u_mem (.chip_select_n_i(csn), .read_strobe_n_i(rd_n),
    .addr_i(maddr), .data_o(mdi));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task final_report;
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // hang guard, far above the under one thousand cycles the run needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report;
    end
  end

  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk_i);
      if (awvalid && awready === 1'b1) awvalid <= 0;
      if (wvalid && wready === 1'b1) wvalid <= 0;
    end while (bvalid !== 1'b1);
    bready <= 0;
    chk(bresp, e);
    // let an edge pass so a next call never re-raises bready at once
    @(posedge clk_i);
  endtask

  task axr(input logic [7:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk_i);
      if (arvalid && arready === 1'b1) arvalid <= 0;
    end while (rvalid !== 1'b1);
    lr = rresp;
    rready <= 0;
    chk(rdata, e);
    @(posedge clk_i);
  endtask

  // one access; latency counted in edges after the accepting edge
  task acc(input logic [1:0] c, input logic [23:0] a, input logic w,
           input logic s, input int lat, input logic pg);
    int n;
    cs <= c;
    addr <= a;
    wr <= w;
    slow <= s;
    rq <= 1;
    do @(posedge clk_i); while (rdy !== 1'b1);
    rq <= 0;
    slow <= 0; // request leaves while the access is still running
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      if (pg && rd_n !== csn[c]) chk(rd_n, csn[c]);
      if (w && wr_n === 1'b0) chk(mdo, 16'h1234);
    end while (rsp !== 1'b1 && n < 2000);
    chk(n, lat);
    if (pg) chk(rdat, (a[15:0] & 16'hFFFE) ^ 16'hC3A5);
    if (pg) chk(bsn, 2'h0);
    @(posedge clk_i);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1;
    for (int i = 0; i < 4; i++) axr(8'(8'h30 + 4 * i), rv[i]);
    axw(8'h40, 32'h0, 2'h2);
    axr(8'h40, 32'h0);
    chk(lr, 2'h2);
    axw(8'h18, 32'hFFFFFFFF, 2'h0);
    axr(8'h18, 32'h01FF01FF);
    axr(8'h08, 32'h00030003);
    acc(0, 24'h000010, 0, 0, 4, 0);
    acc(0, 24'h000010, 0, 1, 3, 0);
    acc(0, 24'h000010, 1, 1, 4, 0);
    // page mode with setups and cycle that must not matter
    axw(8'h00, 32'h3F3F0101, 2'h0);
    axw(8'h04, 32'h0C050101, 2'h0);
    axw(8'h08, 32'h00020003, 2'h0);
    axw(8'h0C, 32'h11001001, 2'h0);
    acc(0, 24'h000100, 0, 0, 13, 1);
    acc(0, 24'h000107, 0, 0, 6, 1);
    acc(0, 24'h000102, 0, 0, 6, 1);
    acc(0, 24'h000108, 0, 0, 13, 1);
    other <= 1;
    @(posedge clk_i);
    other <= 0;
    acc(0, 24'h00010A, 0, 0, 13, 1);
    acc(2, 24'h00010A, 0, 0, 4, 0);
    acc(0, 24'h00010C, 0, 0, 13, 1);
    // new pulse only takes effect with the mode write
    axw(8'h04, 32'h14050101, 2'h0);
    acc(0, 24'h000200, 0, 0, 13, 1);
    axw(8'h0C, 32'h11001001, 2'h0);
    acc(0, 24'h000200, 0, 0, 21, 1);
    // first access shorter than the in-page one, applied as written
    axw(8'h04, 32'h04410101, 2'h0);
    axw(8'h0C, 32'h01001001, 2'h0);
    acc(0, 24'h000300, 0, 0, 5, 1);
    acc(0, 24'h000302, 0, 0, 258, 1);
    axw(8'h04, 32'h0C050101, 2'h0);
    for (int p = 0; p < 4; p++) begin
      axw(8'h0C, 32'h01001001 | (p << 28), 2'h0);
      acc(0, 24'h000400, 0, 0, 13, 1);
      acc(0, 24'(24'h0003FF + (4 << p)), 0, 0, 6, 1);
      acc(0, 24'(24'h000400 + (4 << p)), 0, 0, 13, 1);
    end
    axw(8'h0C, 32'h00001001, 2'h0);
    acc(0, 24'h000400, 0, 0, 3, 0);
    acc(0, 24'h000402, 0, 0, 3, 0);
    final_report;
  end
endmodule // tb_top

bind smpt_page_ctrl smpt_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
  .resp_valid_o(resp_valid_o), .chip_select_n_o(chip_select_n_o),
  .read_strobe_n_o(read_strobe_n_o), .mem_data_oe_o(mem_data_oe_o));

// ---- verilog/smpt_page_ctrl.v ----
// static memory controller core: timing register file, standard
// read/write waveforms, asynchronous page-mode reads, slow clock set
// assumes: one clock, AXI4-Lite master on the register side, one
// requester on the access side, memory data pins behind 2-flop sync
//
// Function
// RQ1 - leaving slow clock, finish transfer with slow set
// RQ2 - page reads only when page mode enabled
// RQ3 - pages aligned to their own size
// RQ4 - upper address selects page, lower byte
// RQ5 - sixteen-bit memories ignore address bit zero
// RQ6 - page reads hold strobe and select low
// RQ7 - first read uses select pulse, next strobe pulse
// RQ8 - read mode, setups, cycle unused in page
// RQ9 - no timing coherency check on pulses
// RQ10 - byte lane kind stays active in page
// RQ11 - software keeps external wait off in page
// RQ12 - same select and page keeps page open
// RQ13 - new select or page starts new page
// RQ14 - intervening access breaks the page
// RQ15 - four registers per select, sixteen-byte slots
// RQ16 - mode register write applies the timing set
// RQ17 - setup length is 128*top plus low five
// RQ18 - pulse length is 256*top plus low six
// RQ19 - software programs read pulses at least one
// RQ20 - page size code 0..3 gives 4..32 bytes
// RQ21 - slow clock request forces fixed waveforms
// RQ22 - reset or disable leaves no open page; a page read in flight at the mode write still reopens it when it ends
`timescale 1ns/10ps
`include "smpt_page_ctrl_map.vh"

module smpt_page_ctrl (
  input  wire        clk_i,
  input  wire        rstn_i,
  // AXI4-Lite register slave
  input  wire [7:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output wire        s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output wire        s_axi_wready_o,
  output wire [1:0]  s_axi_bresp_o,
  output wire        s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [7:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output wire        s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0]  s_axi_rresp_o,
  output wire        s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  // access requests from the system side
  input  wire        req_valid_i,
  output wire        req_ready_o,
  input  wire        req_write_i,
  input  wire [1:0]  req_cs_i,
  input  wire [23:0] req_addr_i,
  input  wire [1:0]  req_be_i,
  input  wire [15:0] req_wdata_i,
  output wire        resp_valid_o,
  output wire [15:0] resp_rdata_o,
  input  wire        other_access_i,
  input  wire        slow_clk_req_i,
  // memory pins
  output wire [3:0]  chip_select_n_o,
  output wire        read_strobe_n_o,
  output wire        write_strobe_n_o,
  output wire [1:0]  byte_sel_n_o,
  output wire [23:0] mem_addr_o,
  output wire [15:0] mem_data_o,
  output wire        mem_data_oe_o,
  input  wire [15:0] mem_data_i
);

  // ---------------------------------------------------------------
  // length decoding
  // ---------------------------------------------------------------
  function [9:0] setup_len;
    input [5:0] f;
    setup_len = {2'b00, f[5], 2'h0, f[4:0]};    // [RQ17]
  endfunction

  function [9:0] pulse_len;
    input [6:0] f;
    pulse_len = {1'b0, f[6], 2'h0, f[5:0]};     // [RQ18]
  endfunction

  function [9:0] cycle_len;
    input [8:0] f;
    cycle_len = {f[8:7], 1'b0, f[6:0]};
  endfunction

  // page address mask: 4 << size code bytes per page
  function [23:0] page_mask;
    input [1:0] ps;
    case (ps)
      2'h0:    page_mask = 24'hFFFFFC;          // [RQ20] [RQ4]
      2'h1:    page_mask = 24'hFFFFF8;
      2'h2:    page_mask = 24'hFFFFF0;
      default: page_mask = 24'hFFFFE0;
    endcase
  endfunction

  localparam [1:0] S_IDLE  = 2'h0;
  localparam [1:0] S_STD   = 2'h1;
  localparam [1:0] S_PAGE  = 2'h2;
  localparam [1:0] S_BREAK = 2'h3;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  reg  [31:0] prog_reg [0:15];      // index = cs*4 + register
  reg  [31:0] act_setup_reg [0:3];  // timing in force per select
  reg  [31:0] act_pulse_reg [0:3];
  reg  [31:0] act_cycle_reg [0:3];
  reg         aw_got_reg;
  reg         w_got_reg;
  reg  [7:0]  aw_addr_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         bvalid_reg;
  reg  [1:0]  bresp_reg;
  reg         rvalid_reg;
  reg  [1:0]  rresp_reg;
  reg  [31:0] rdata_reg;
  wire        wr_fire = aw_got_reg & w_got_reg & ~bvalid_reg;
  wire        wr_map  = (aw_addr_reg[7:6] == 2'h0);
  wire [3:0]  wr_idx  = aw_addr_reg[5:2];
  wire        mode_wr = wr_fire & wr_map &
                        (wr_idx[1:0] == `SMPT_OFS_MODE);
  reg  [31:0] msk;
  reg  [31:0] wmerge;
  integer     i;
  integer     j;                    // reset loop only, one driver each

  assign s_axi_awready_o = ~aw_got_reg & ~bvalid_reg;
  assign s_axi_wready_o  = ~w_got_reg & ~bvalid_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = ~rvalid_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rresp_o   = rresp_reg;
  assign s_axi_rdata_o   = rdata_reg;

  // byte-lane merge with reserved bits forced to zero
  always @* begin
    case (wr_idx[1:0])
      `SMPT_OFS_SETUP: msk = `SMPT_MSK_SETUP;
      `SMPT_OFS_PULSE: msk = `SMPT_MSK_PULSE;
      `SMPT_OFS_CYCLE: msk = `SMPT_MSK_CYCLE;
      default:         msk = `SMPT_MSK_MODE;
    endcase
    wmerge = prog_reg[wr_idx];
    for (i = 0; i < 4; i = i + 1) begin
      if (w_strb_reg[i]) begin
        wmerge[i*8 +: 8] = w_data_reg[i*8 +: 8];
      end
    end
    wmerge = wmerge & msk;
  end

  // address and data channels taken in either order, one at a time
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= `SMPT_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= `SMPT_RESP_OKAY;
      rdata_reg  <= 32'h00000000;
      for (j = 0; j < 4; j = j + 1) begin
        prog_reg[j*4]     <= `SMPT_RST_SETUP;    // [RQ15]
        prog_reg[j*4 + 1] <= `SMPT_RST_PULSE;
        prog_reg[j*4 + 2] <= `SMPT_RST_CYCLE;
        prog_reg[j*4 + 3] <= `SMPT_RST_MODE;
        act_setup_reg[j]  <= `SMPT_RST_SETUP;
        act_pulse_reg[j]  <= `SMPT_RST_PULSE;
        act_cycle_reg[j]  <= `SMPT_RST_CYCLE;
      end
    end else begin
      if (s_axi_awvalid_i && !aw_got_reg && !bvalid_reg) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_got_reg && !bvalid_reg) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_map ? `SMPT_RESP_OKAY : `SMPT_RESP_SLVERR;
        if (wr_map) begin
          prog_reg[wr_idx] <= wmerge;
        end
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
      // timing set takes effect only on the mode write
      if (mode_wr) begin                                   // [RQ16]
        act_setup_reg[wr_idx[3:2]] <= prog_reg[{wr_idx[3:2], 2'h0}];
        act_pulse_reg[wr_idx[3:2]] <= prog_reg[{wr_idx[3:2], 2'h1}];
        act_cycle_reg[wr_idx[3:2]] <= prog_reg[{wr_idx[3:2], 2'h2}];
      end
      if (s_axi_arvalid_i && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        if (s_axi_araddr_i[7:6] == 2'h0) begin
          rdata_reg <= prog_reg[s_axi_araddr_i[5:2]];
          rresp_reg <= `SMPT_RESP_OKAY;
        end else begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= `SMPT_RESP_SLVERR;
        end
      end else if (rvalid_reg && s_axi_rready_i) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  reg  [15:0] din_meta_reg;
  reg  [15:0] din_sync_reg;
  reg  [1:0]  state_reg;
  reg  [9:0]  cnt_reg;
  reg         cur_write_reg;
  reg  [1:0]  cur_cs_reg;
  reg  [23:0] cur_addr_reg;
  reg  [1:0]  cur_be_reg;
  reg  [15:0] cur_wdata_reg;
  reg  [9:0]  cs_su_reg;
  reg  [9:0]  cs_pl_reg;
  reg  [9:0]  st_su_reg;
  reg  [9:0]  st_pl_reg;
  reg  [9:0]  cyc_reg;
  reg         ctl_strobe_reg;    // read controlled by strobe
  reg         page_open_reg;
  reg  [1:0]  page_cs_reg;
  reg  [23:0] page_addr_reg;
  reg         resp_valid_reg;
  reg  [15:0] resp_rdata_reg;

  wire [31:0] r_mode  = prog_reg[{req_cs_i, `SMPT_OFS_MODE}];
  wire [31:0] r_setup = act_setup_reg[req_cs_i];
  wire [31:0] r_pulse = act_pulse_reg[req_cs_i];
  wire [31:0] r_cycle = act_cycle_reg[req_cs_i];
  wire        r_page_mode_on  = r_mode[`SMPT_F_PAGE_MODE_ON];
  wire [23:0] r_mask  = page_mask(r_mode[`SMPT_F_PS +: 2]);
  // page reads only with page mode on and normal clock
  wire        r_page  = ~req_write_i & r_page_mode_on & ~slow_clk_req_i; // [RQ2]
  // same select and same page bits, sequential or not
  wire        r_hit   = page_open_reg & (req_cs_i == page_cs_reg) &
                        ((req_addr_i & r_mask) ==
                         (page_addr_reg & r_mask));  // [RQ3] [RQ12]
  wire        accept  = req_valid_i & req_ready_o;
  wire [9:0]  r_first = pulse_len(r_pulse[`SMPT_F_RD_CS +: 7]);
  wire [9:0]  r_next  = pulse_len(r_pulse[`SMPT_F_RD_ST +: 7]);
  wire [9:0]  r_plen  = r_hit ? r_next : r_first;   // [RQ7] [RQ9]
  wire [9:0]  std_end = (cyc_reg == 10'h000) ? 10'h000 :
                        (cyc_reg - 10'h001);
  wire [9:0]  ctl_su  = ctl_strobe_reg ? st_su_reg : cs_su_reg;
  wire [9:0]  ctl_pl  = ctl_strobe_reg ? st_pl_reg : cs_pl_reg;
  wire [9:0]  ctl_end = ctl_su + ((ctl_pl == 10'h000) ? 10'h000 :
                        (ctl_pl - 10'h001));
  wire [9:0]  pg_end  = (cs_pl_reg == 10'h000) ? 10'h000 :
                        (cs_pl_reg - 10'h001);
  // a new access that is not a page hit must see the select drop
  wire        closing = page_open_reg &
                        (other_access_i | (req_valid_i &
                         ~(r_page & r_hit)));        // [RQ13] [RQ14]

  assign req_ready_o  = (state_reg == S_IDLE) & ~closing;
  assign resp_valid_o = resp_valid_reg;
  assign resp_rdata_o = resp_rdata_reg;

  // memory data pins pass two flops before use
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      din_meta_reg <= 16'h0000;
      din_sync_reg <= 16'h0000;
    end else begin
      din_meta_reg <= mem_data_i;
      din_sync_reg <= din_meta_reg;
    end
  end

  // sequencer; timing set is frozen when the access is taken, so a
  // slow clock request that drops mid-access does not change it
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg      <= S_IDLE;
      cnt_reg        <= 10'h000;
      cur_write_reg  <= 1'b0;
      cur_cs_reg     <= 2'h0;
      cur_addr_reg   <= 24'h000000;
      cur_be_reg     <= 2'h0;
      cur_wdata_reg  <= 16'h0000;
      cs_su_reg      <= 10'h000;
      cs_pl_reg      <= 10'h000;
      st_su_reg      <= 10'h000;
      st_pl_reg      <= 10'h000;
      cyc_reg        <= 10'h000;
      ctl_strobe_reg <= 1'b0;
      page_open_reg  <= 1'b0;                              // [RQ22]
      page_cs_reg    <= 2'h0;
      page_addr_reg  <= 24'h000000;
      resp_valid_reg <= 1'b0;
      resp_rdata_reg <= 16'h0000;
    end else begin
      resp_valid_reg <= 1'b0;
      // new timing or page mode turned off: forget the open page, which a page read in flight still reopens when it ends
      if (mode_wr || (closing && state_reg == S_IDLE)) begin
        page_open_reg <= 1'b0;                             // [RQ22]
      end
      case (state_reg)
        S_IDLE: begin
          if (closing) begin
            state_reg <= S_BREAK;
          end else if (accept) begin
            cur_write_reg <= req_write_i;
            cur_cs_reg    <= req_cs_i;
            cur_addr_reg  <= req_addr_i;
            cur_be_reg    <= req_be_i;
            cur_wdata_reg <= req_wdata_i;
            cnt_reg       <= 10'h000;
            ctl_strobe_reg <= r_mode[`SMPT_F_RDMODE];
            if (r_page) begin
              // setups, cycle and read mode play no part here
              cs_pl_reg <= r_plen;                         // [RQ8]
              state_reg <= S_PAGE;
            end else if (slow_clk_req_i) begin
              state_reg <= S_STD;                          // [RQ21]
              ctl_strobe_reg <= 1'b1;
              if (req_write_i) begin
                cs_su_reg <= `SMPT_SLOW_WR_CS_SU;
                cs_pl_reg <= `SMPT_SLOW_WR_CS_PL;
                st_su_reg <= `SMPT_SLOW_WR_ST_SU;
                st_pl_reg <= `SMPT_SLOW_WR_ST_PL;
                cyc_reg   <= `SMPT_SLOW_WR_CYC;
              end else begin
                cs_su_reg <= `SMPT_SLOW_RD_CS_SU;
                cs_pl_reg <= `SMPT_SLOW_RD_CS_PL;
                st_su_reg <= `SMPT_SLOW_RD_ST_SU;
                st_pl_reg <= `SMPT_SLOW_RD_ST_PL;
                cyc_reg   <= `SMPT_SLOW_RD_CYC;
              end
            end else begin
              state_reg <= S_STD;
              if (req_write_i) begin
                cs_su_reg <= setup_len(r_setup[`SMPT_F_WR_CS +: 6]);
                cs_pl_reg <= pulse_len(r_pulse[`SMPT_F_WR_CS +: 7]);
                st_su_reg <= setup_len(r_setup[`SMPT_F_WR_ST +: 6]);
                st_pl_reg <= pulse_len(r_pulse[`SMPT_F_WR_ST +: 7]);
                cyc_reg   <= cycle_len(r_cycle[`SMPT_F_WRCYC +: 9]);
              end else begin
                cs_su_reg <= setup_len(r_setup[`SMPT_F_RD_CS +: 6]);
                cs_pl_reg <= r_first;
                st_su_reg <= setup_len(r_setup[`SMPT_F_RD_ST +: 6]);
                st_pl_reg <= r_next;
                cyc_reg   <= cycle_len(r_cycle[`SMPT_F_RDCYC +: 9]);
              end
            end
          end
        end
        S_STD: begin
          // slow set stays in force to the end of this access
          if (!cur_write_reg && cnt_reg == ctl_end) begin  // [RQ1]
            resp_rdata_reg <= din_sync_reg;
          end
          if (cnt_reg >= std_end) begin
            state_reg      <= S_IDLE;
            resp_valid_reg <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 10'h001;
          end
        end
        S_PAGE: begin
          // no check that first length exceeds the later one
          if (cnt_reg >= pg_end) begin                     // [RQ9]
            resp_rdata_reg <= din_sync_reg;
            resp_valid_reg <= 1'b1;
            state_reg      <= S_IDLE;
            page_open_reg  <= 1'b1;
            page_cs_reg    <= cur_cs_reg;
            page_addr_reg  <= cur_addr_reg;
          end else begin
            cnt_reg <= cnt_reg + 10'h001;
          end
        end
        default: begin
          // one cycle with every select high between accesses
          state_reg <= S_IDLE;                             // [RQ14]
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drive, registered
  // ---------------------------------------------------------------
  reg  [3:0]  cs_n_reg;
  reg         rd_n_reg;
  reg         wr_n_reg;
  reg  [1:0]  bsel_n_reg;
  reg  [23:0] addr_reg;
  reg  [15:0] dout_reg;
  reg         doe_reg;
  reg         cs_on;
  reg         st_on;
  reg         pg_on;
  wire [31:0] c_mode = prog_reg[{cur_cs_reg, `SMPT_OFS_MODE}];
  wire        c_16   = (c_mode[`SMPT_F_DBW +: 2] == 2'h1);
  wire        c_bsel = ~c_mode[`SMPT_F_BAT];

  always @* begin
    cs_on = (state_reg == S_STD) & (cnt_reg >= cs_su_reg) &
            (cnt_reg < cs_su_reg + cs_pl_reg);
    st_on = (state_reg == S_STD) & (cnt_reg >= st_su_reg) &
            (cnt_reg < st_su_reg + st_pl_reg);
    // select and strobe low together for the whole page run
    pg_on = (state_reg == S_PAGE) |
            ((state_reg == S_IDLE) & page_open_reg & ~closing); // [RQ6]
  end

  // pins lag the sequencer by one cycle, same for every signal
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      cs_n_reg   <= 4'hF;
      rd_n_reg   <= 1'b1;
      wr_n_reg   <= 1'b1;
      bsel_n_reg <= 2'h3;
      addr_reg   <= 24'h000000;
      dout_reg   <= 16'h0000;
      doe_reg    <= 1'b0;
    end else begin
      cs_n_reg <= 4'hF;
      if (cs_on || pg_on) begin
        cs_n_reg[cur_cs_reg] <= 1'b0;
      end
      rd_n_reg <= ~((st_on & ~cur_write_reg) | pg_on);
      wr_n_reg <= ~(st_on & cur_write_reg);
      // byte select follows the select; byte write follows strobe
      if (c_16 && c_bsel) begin                            // [RQ10]
        bsel_n_reg <= ~(cur_be_reg & {2{cs_on | pg_on}});
      end else if (c_16) begin
        bsel_n_reg <= ~(cur_be_reg & {2{st_on & cur_write_reg}});
      end else begin
        bsel_n_reg <= 2'h3;
      end
      addr_reg <= {cur_addr_reg[23:1],
                   cur_addr_reg[0] & ~c_16};               // [RQ5]
      dout_reg <= cur_wdata_reg;
      doe_reg  <= cs_on & cur_write_reg;
    end
  end

  assign chip_select_n_o  = cs_n_reg;
  assign read_strobe_n_o  = rd_n_reg;
  assign write_strobe_n_o = wr_n_reg;
  assign byte_sel_n_o     = bsel_n_reg;
  assign mem_addr_o       = addr_reg;
  assign mem_data_o       = dout_reg;
  assign mem_data_oe_o    = doe_reg;

endmodule // smpt_page_ctrl

// ---- verilog/smpt_page_ctrl_map.vh ----
// constants of the static memory page-mode timing block
// assumes: included by the controller file only, by bare name
`ifndef SMPT_PAGE_CTRL_MAP_VH
`define SMPT_PAGE_CTRL_MAP_VH

// register slot per chip select and offsets within the slot
`define SMPT_CS_STRIDE      8'h10
`define SMPT_OFS_SETUP      2'h0
`define SMPT_OFS_PULSE      2'h1
`define SMPT_OFS_CYCLE      2'h2
`define SMPT_OFS_MODE       2'h3
`define SMPT_NUM_CS         4

// reset values
`define SMPT_RST_SETUP      32'h01010101
`define SMPT_RST_PULSE      32'h01010101
`define SMPT_RST_CYCLE      32'h00030003
`define SMPT_RST_MODE       32'h10002103

// writable bits, reserved bits read as zero
`define SMPT_MSK_SETUP      32'h3F3F3F3F
`define SMPT_MSK_PULSE      32'h7F7F7F7F
`define SMPT_MSK_CYCLE      32'h01FF01FF
`define SMPT_MSK_MODE       32'h311F3133

// field positions (low bit)
`define SMPT_F_RD_CS        24
`define SMPT_F_RD_ST        16
`define SMPT_F_WR_CS        8
`define SMPT_F_WR_ST        0
`define SMPT_F_RDCYC        16
`define SMPT_F_WRCYC        0
`define SMPT_F_PS           28
`define SMPT_F_PAGE_MODE_ON         24
`define SMPT_F_DBW          12
`define SMPT_F_BAT          8
`define SMPT_F_RDMODE       0

// fixed slow clock waveform set, in cycles
`define SMPT_SLOW_RD_ST_SU  10'h001
`define SMPT_SLOW_RD_ST_PL  10'h001
`define SMPT_SLOW_RD_CS_SU  10'h000
`define SMPT_SLOW_RD_CS_PL  10'h002
`define SMPT_SLOW_RD_CYC    10'h002
`define SMPT_SLOW_WR_ST_SU  10'h001
`define SMPT_SLOW_WR_ST_PL  10'h001
`define SMPT_SLOW_WR_CS_SU  10'h000
`define SMPT_SLOW_WR_CS_PL  10'h003
`define SMPT_SLOW_WR_CYC    10'h003

// bus answers
`define SMPT_RESP_OKAY      2'h0
`define SMPT_RESP_SLVERR    2'h2

`endif
